/* File: src/sase_pkg.sv */
package sase_pkg;
  localparam logic [1:0] OP_FMT2      = 2'h0;
  localparam logic [1:0] OP_MEM       = 2'h3;
  localparam logic [2:0] FMT2_SETHI   = 3'h4;
  localparam logic [5:0] OPX_CWORD    = 6'h34;
  localparam logic [5:0] OPX_CDBL     = 6'h37;
  localparam logic [5:0] OPX_CSTAT    = 6'h35;
  localparam logic [5:0] OPX_CQUE     = 6'h36;
  localparam logic [5:0] OPX_LDSTUB   = 6'h0d;
  localparam logic [5:0] OPX_LDSTUBA  = 6'h1d;
  localparam logic [5:0] OPX_SWAP     = 6'h0f;
  localparam logic [5:0] OPX_SWAPA    = 6'h1f;
  localparam int         IMM_SEL_BIT  = 13;
  localparam int         ASI_LSB      = 5;
  localparam int         SIMM_W       = 13;
  localparam int         HIMM_W       = 22;
  localparam int         LOW_ZERO_W   = 10;
  localparam logic [7:0] ASI_USER_DATA = 8'h0a;
  localparam logic [7:0] ASI_SUP_DATA  = 8'h0b;
  localparam logic [7:0] BYTE_ONES     = 8'hff;
  // Trap causes
  localparam logic [3:0] TRAP_NONE    = 4'h0;
  localparam logic [3:0] TRAP_ILLEGAL = 4'h1;
  localparam logic [3:0] TRAP_PRIV    = 4'h2;
  localparam logic [3:0] TRAP_COP_OFF = 4'h3;
  localparam logic [3:0] TRAP_COP_FLT = 4'h4;
  localparam logic [3:0] TRAP_ALIGN   = 4'h5;
  localparam logic [3:0] TRAP_DACC    = 4'h6;
  // Memory access sizes
  localparam logic [1:0] SZ_BYTE      = 2'h0;
  localparam logic [1:0] SZ_WORD      = 2'h2;
  localparam logic [1:0] SZ_DWORD     = 2'h3;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b00_0001,
    ST_LOAD  = 6'b00_0010,
    ST_STORE = 6'b00_0100,
    ST_COPRD = 6'b00_1000,
    ST_CSTOR = 6'b01_0000,
    ST_DONE  = 6'b10_0000
  } sase_state_t;
endpackage : sase_pkg

/* File: src/sase_decode.sv */
module sase_decode
  import sase_pkg::*;
(
  input  wire logic [31:0] instr,
  input  wire logic        super_bit,
  input  wire logic        cop_enable_bit,
  input  wire logic        cop_present,
  input  wire logic        cop_queue_impl,
  input  wire logic [31:0] ea,
  output logic             is_cop_store,
  output logic             is_cop_dbl,
  output logic             is_atomic,
  output logic             is_swap,
  output logic             is_sethi,
  output logic             is_nop,
  output logic             is_alt,
  output logic [3:0]       trap_cause
);
  logic [1:0] op;
  logic [5:0] opcode_ext_field;
  logic       imm_sel;
  logic       is_cop_one;
  logic       is_cop_stat;
  logic       is_stq;
  logic       is_priv;
  logic       is_mis_w;
  logic       is_mis_d;

  assign op               = instr[31:30];
  assign opcode_ext_field = instr[24:19];
  assign imm_sel          = instr[IMM_SEL_BIT];
  assign is_sethi = (op == OP_FMT2) && (instr[24:22] == FMT2_SETHI); // RQ18
  assign is_nop   = is_sethi && (instr[29:25] == 5'h0)
                    && (instr[21:0] == 22'h0); // RQ21
  assign is_cop_one = (op == OP_MEM) && (opcode_ext_field == OPX_CWORD); // RQ1
  assign is_cop_dbl = (op == OP_MEM) && (opcode_ext_field == OPX_CDBL); // RQ2
  assign is_cop_stat = (op == OP_MEM) && (opcode_ext_field == OPX_CSTAT); // RQ3
  assign is_stq   = (op == OP_MEM) && (opcode_ext_field == OPX_CQUE); // RQ4
  assign is_cop_store = is_cop_one | is_cop_dbl | is_cop_stat | is_stq;
  assign is_atomic = (op == OP_MEM) && ((opcode_ext_field == OPX_LDSTUB)
                     || (opcode_ext_field == OPX_LDSTUBA)); // RQ9
  assign is_swap  = (op == OP_MEM) && ((opcode_ext_field == OPX_SWAP)
                     || (opcode_ext_field == OPX_SWAPA)); // RQ15
  assign is_alt   = (op == OP_MEM) && ((opcode_ext_field == OPX_LDSTUBA)
                     || (opcode_ext_field == OPX_SWAPA));
  assign is_priv  = is_alt | is_stq;
  assign is_mis_w = ea[1:0] != 2'h0;
  assign is_mis_d = ea[2:0] != 3'h0;

  // Priority: illegal, privilege, cop disabled, cop fault, alignment
  always_comb begin
    trap_cause = TRAP_NONE;
    if (is_alt && imm_sel) begin
      trap_cause = TRAP_ILLEGAL; // RQ13
    end else if (is_priv && !super_bit) begin
      trap_cause = TRAP_PRIV; // RQ23
    end else if (is_cop_store && (!cop_enable_bit || !cop_present)) begin
      trap_cause = TRAP_COP_OFF; // RQ8
    end else if (is_stq && !cop_queue_impl) begin
      trap_cause = TRAP_COP_FLT; // RQ5
    end else if (((is_cop_one | is_cop_stat | is_swap) && is_mis_w)
                 || ((is_cop_dbl | is_stq) && is_mis_d)) begin
      trap_cause = TRAP_ALIGN; // RQ7 RQ16
    end
  end
endmodule : sase_decode

/* File: src/sase_agen.sv */
module sase_agen
  import sase_pkg::*;
(
  input  wire logic [31:0] src_reg_a,
  input  wire logic [31:0] src_reg_b,
  input  wire logic [31:0] instr,
  output logic [31:0]      ea
);
  function automatic logic [31:0] sext13(input logic [12:0] v);
    sext13 = {{(32 - SIMM_W){v[SIMM_W-1]}}, v};
  endfunction : sext13

  logic [12:0] signed_imm_field;
  assign signed_imm_field = instr[12:0];
  assign ea = instr[IMM_SEL_BIT] ? src_reg_a + sext13(signed_imm_field)
                                 : src_reg_a + src_reg_b; // RQ6
endmodule : sase_agen

/* File: src/sase_exec.sv */
// Notes on behaviour
// RQ1 - Coprocessor single store writes selected coprocessor register to EA.
// RQ2 - Coprocessor double store writes a coprocessor register pair to EA.
// RQ3 - Coprocessor state-register store writes the state register to memory.
// RQ4 - Privileged queue store pops front queue entry and writes it to memory.
// RQ5 - Without a coprocessor queue, queue store takes coprocessor fault trap.
// RQ6 - EA is src a plus src b, or src a plus sign-extended immediate.
// RQ7 - Single/state stores need word alignment; double/queue need doubleword.
// RQ8 - Coprocessor stores trap disabled if enable bit clear or none present.
// RQ9 - Atomic byte load-store decodes 001101; alternate form 011101 privileged.
// RQ10 - Atomic byte zero-extends loaded byte to rd, then writes all ones.
// RQ11 - Atomic load and store complete with no interrupt between them.
// RQ12 - Memory serializes concurrent atomics to the same location.
// RQ13 - Alternate atomic forms with immediate select set trap illegal.
// RQ14 - Alternate forms use ASI field; others user/system space by S bit.
// RQ15 - Swap decodes 001111, alternate 011111; exchanges rd with memory word.
// RQ16 - Swap forms trap on a non-word-aligned effective address.
// RQ17 - Store half may fault after load; rd may already hold loaded value.
// RQ18 - Set-high is format two, op 00, format-two opcode 100, 22-bit field.
// RQ19 - Set-high writes immediate to upper 22 bits, clears low 10 bits.
// RQ20 - Set-high leaves condition codes unchanged.
// RQ21 - Set-high with zero rd and zero immediate is a no-operation.
// RQ22 - Trapped instruction leaves memory and rd unchanged; r0 writes dropped.
// RQ23 - Privileged forms trap privileged when supervisor bit is clear.
module sase_exec
  import sase_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        issue_valid,
  input  wire logic [31:0] instr,
  input  wire logic [31:0] src_reg_a,
  input  wire logic [31:0] src_reg_b,
  input  wire logic [31:0] rd_value,
  input  wire logic        super_bit,
  input  wire logic        cop_enable_bit,
  input  wire logic        cop_present,
  input  wire logic        cop_queue_impl,
  input  wire logic [3:0]  icc_in,
  input  wire logic        mem_ready,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        mem_fault,
  input  wire logic        cop_data_valid,
  input  wire logic [63:0] cop_data,
  output logic             busy_q,
  output logic             done_q,
  output logic             trap_q,
  output logic [3:0]       trap_cause_q,
  output logic             irq_block_q,
  output logic             rd_we_q,
  output logic [4:0]       rd_addr_q,
  output logic [31:0]      rd_wdata_q,
  output logic [3:0]       icc_q,
  output logic             mem_req_q,
  output logic             mem_we_q,
  output logic             mem_lock_q,
  output logic [31:0]      mem_addr_q,
  output logic [1:0]       mem_size_q,
  output logic [7:0]       mem_asi_q,
  output logic [63:0]      mem_wdata_q,
  output logic             cop_req_q,
  output logic [1:0]       cop_sel_q,
  output logic [4:0]       cop_reg_q,
  output logic             cop_pop_q
);
  logic [31:0] ea;
  logic        is_cop_store;
  logic        is_cop_dbl;
  logic        is_atomic;
  logic        is_swap;
  logic        is_sethi;
  logic        is_nop;
  logic        is_alt;
  logic [3:0]  trap_cause;
  logic [4:0]  rd_fld;
  logic [7:0]  asi_sel;
  logic [31:0] sethi_val;
  logic [31:0] load_val;
  logic        accept;
  sase_state_t state_q;
  sase_state_t state_d;
  logic        is_swap_q;
  logic [31:0] swap_src_q;

  sase_agen u_agen (
    .src_reg_a (src_reg_a),
    .src_reg_b (src_reg_b),
    .instr     (instr),
    .ea        (ea)
  );

  sase_decode u_dec (
    .instr          (instr),
    .super_bit      (super_bit),
    .cop_enable_bit (cop_enable_bit),
    .cop_present    (cop_present),
    .cop_queue_impl (cop_queue_impl),
    .ea             (ea),
    .is_cop_store   (is_cop_store),
    .is_cop_dbl     (is_cop_dbl),
    .is_atomic      (is_atomic),
    .is_swap        (is_swap),
    .is_sethi       (is_sethi),
    .is_nop         (is_nop),
    .is_alt         (is_alt),
    .trap_cause     (trap_cause)
  );

  assign rd_fld   = instr[29:25];
  assign accept   = issue_valid && (state_q == ST_IDLE);
  assign asi_sel  = is_alt ? instr[ASI_LSB +: 8]
                  : (super_bit ? ASI_SUP_DATA : ASI_USER_DATA); // RQ14
  assign sethi_val = {instr[HIMM_W-1:0], {LOW_ZERO_W{1'b0}}}; // RQ19
  // Byte lane picked by low address bits, big-endian order
  assign load_val = is_swap_q ? mem_rdata
                  : {24'h00_0000, mem_rdata[(5'd24 - {mem_addr_q[1:0], 3'h0})
                     +: 8]}; // RQ10

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (accept && trap_cause == TRAP_NONE) begin
          if (is_atomic || is_swap) begin
            state_d = ST_LOAD;
          end else if (is_cop_store) begin
            state_d = ST_COPRD;
          end else begin
            state_d = ST_DONE;
          end
        end else if (accept) begin
          state_d = ST_DONE;
        end
      end
      ST_LOAD: begin
        if (mem_ready) begin
          state_d = mem_fault ? ST_DONE : ST_STORE;
        end
      end
      ST_STORE: begin
        if (mem_ready) begin
          state_d = ST_DONE;
        end
      end
      ST_COPRD: begin
        if (cop_data_valid) begin
          state_d = ST_CSTOR;
        end
      end
      ST_CSTOR: begin
        if (mem_ready) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE:  state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q       <= 1'b0;
      done_q       <= 1'b0;
      trap_q       <= 1'b0;
      trap_cause_q <= TRAP_NONE;
      irq_block_q  <= 1'b0;
      rd_we_q      <= 1'b0;
      rd_addr_q    <= 5'h00;
      rd_wdata_q   <= 32'h0000_0000;
      icc_q        <= 4'h0;
      mem_req_q    <= 1'b0;
      mem_we_q     <= 1'b0;
      mem_lock_q   <= 1'b0;
      mem_addr_q   <= 32'h0000_0000;
      mem_size_q   <= SZ_BYTE;
      mem_asi_q    <= 8'h00;
      mem_wdata_q  <= 64'h0000_0000_0000_0000;
      cop_req_q    <= 1'b0;
      cop_sel_q    <= 2'h0;
      cop_reg_q    <= 5'h00;
      cop_pop_q    <= 1'b0;
      is_swap_q    <= 1'b0;
      swap_src_q   <= 32'h0000_0000;
    end else begin
      done_q    <= state_d == ST_DONE;
      busy_q    <= state_d != ST_IDLE;
      rd_we_q   <= 1'b0;
      cop_pop_q <= 1'b0;
      icc_q     <= icc_in; // RQ20
      if (state_q == ST_IDLE) begin
        trap_q <= 1'b0;
      end
      if (accept) begin
        trap_q       <= trap_cause != TRAP_NONE;
        trap_cause_q <= trap_cause;
        rd_addr_q    <= rd_fld;
        mem_addr_q   <= ea;
        mem_asi_q    <= asi_sel;
        is_swap_q    <= is_swap;
        swap_src_q   <= rd_value;
        // Trapped or nop instructions write nothing
        if (trap_cause == TRAP_NONE) begin // RQ22
          if (is_sethi && !is_nop && rd_fld != 5'h00) begin
            rd_we_q    <= 1'b1; // RQ19 RQ21
            rd_wdata_q <= sethi_val;
          end
          if (is_atomic || is_swap) begin
            mem_req_q   <= 1'b1;
            mem_we_q    <= 1'b0;
            mem_lock_q  <= 1'b1; // RQ12
            irq_block_q <= 1'b1; // RQ11
            mem_size_q  <= is_swap ? SZ_WORD : SZ_BYTE;
          end
          if (is_cop_store) begin
            cop_req_q <= 1'b1;
            cop_reg_q <= rd_fld;
            cop_sel_q <= instr[20:19]; // RQ1 RQ2 RQ3 RQ4
            mem_size_q <= is_cop_dbl || (instr[24:19] == OPX_CQUE)
                          ? SZ_DWORD : SZ_WORD;
          end
        end
      end
      if (state_q == ST_LOAD && mem_ready) begin
        rd_we_q    <= rd_addr_q != 5'h00; // RQ17
        rd_wdata_q <= load_val;
        if (mem_fault) begin
          mem_req_q    <= 1'b0;
          mem_lock_q   <= 1'b0;
          irq_block_q  <= 1'b0;
          rd_we_q      <= 1'b0;
          trap_q       <= 1'b1;
          trap_cause_q <= TRAP_DACC;
        end else begin
          mem_we_q    <= 1'b1;
          mem_wdata_q <= is_swap_q ? {32'h0000_0000, swap_src_q}
                       : {56'h0, BYTE_ONES}; // RQ10 RQ15
        end
      end
      if (state_q == ST_STORE && mem_ready) begin
        mem_req_q   <= 1'b0;
        mem_we_q    <= 1'b0;
        mem_lock_q  <= 1'b0;
        irq_block_q <= 1'b0;
        if (mem_fault) begin
          trap_q       <= 1'b1; // RQ17
          trap_cause_q <= TRAP_DACC;
        end
      end
      if (state_q == ST_COPRD && cop_data_valid) begin
        cop_req_q   <= 1'b0;
        cop_pop_q   <= cop_sel_q == OPX_CQUE[1:0]; // RQ4
        mem_req_q   <= 1'b1;
        mem_we_q    <= 1'b1;
        mem_wdata_q <= cop_data;
      end
      if (state_q == ST_CSTOR && mem_ready) begin
        mem_req_q <= 1'b0;
        mem_we_q  <= 1'b0;
        if (mem_fault) begin
          trap_q       <= 1'b1;
          trap_cause_q <= TRAP_DACC;
        end
      end
    end
  end

  chk_sethi_low_zero: assert property (@(posedge mclk) // RQ19
    disable iff (!rst_n)
    (accept && is_sethi && trap_cause == TRAP_NONE && rd_fld != 5'h00)
    |=> (rd_we_q && rd_wdata_q[9:0] == 10'h000))
    else $error("set-high low bits not cleared");
  chk_nop_no_write: assert property (@(posedge mclk) // RQ21
    disable iff (!rst_n)
    (accept && is_nop) |=> !rd_we_q)
    else $error("nop wrote a register");
  chk_trap_no_mem: assert property (@(posedge mclk) // RQ22
    disable iff (!rst_n)
    (accept && trap_cause != TRAP_NONE) |=> (!mem_req_q && trap_q))
    else $error("trapped instruction accessed memory");
  chk_lock_during: assert property (@(posedge mclk) // RQ11
    disable iff (!rst_n)
    (state_q == ST_STORE) |-> (irq_block_q && mem_lock_q))
    else $error("atomic store not locked");
  chk_ones_store: assert property (@(posedge mclk) // RQ10
    disable iff (!rst_n)
    (state_q == ST_STORE && !is_swap_q) |-> mem_wdata_q[7:0] == BYTE_ONES)
    else $error("atomic byte store not all ones");
  chk_r0_discard: assert property (@(posedge mclk) // RQ22
    disable iff (!rst_n)
    rd_we_q |-> rd_addr_q != 5'h00)
    else $error("write to register zero");
  chk_priv_trap: assert property (@(posedge mclk) // RQ23
    disable iff (!rst_n)
    (accept && is_alt && !instr[IMM_SEL_BIT] && !super_bit)
    |=> (trap_cause_q == TRAP_PRIV))
    else $error("privileged form not trapped");
  chk_cop_off: assert property (@(posedge mclk) // RQ8
    disable iff (!rst_n)
    (accept && is_cop_store && !cop_enable_bit && super_bit)
    |=> (trap_q && trap_cause_q == TRAP_COP_OFF))
    else $error("disabled coprocessor store not trapped");
  chk_align_trap: assert property (@(posedge mclk) // RQ16
    disable iff (!rst_n)
    (accept && is_swap && !is_alt && ea[1:0] != 2'h0)
    |=> (trap_cause_q == TRAP_ALIGN))
    else $error("misaligned swap not trapped");
  chk_icc_kept: assert property (@(posedge mclk) // RQ20
    disable iff (!rst_n)
    (accept && is_sethi) |=> icc_q == $past(icc_in))
    else $error("set-high altered condition codes");
endmodule : sase_exec

/* File: test/sase_mem_model.sv */
module sase_mem_model
  import sase_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic [1:0]  lat,
  input  wire logic        fault_store,
  input  wire logic [63:0] cop_word,
  input  wire logic        mem_req_q,
  input  wire logic        mem_we_q,
  input  wire logic [31:0] mem_addr_q,
  input  wire logic [1:0]  mem_size_q,
  input  wire logic [63:0] mem_wdata_q,
  input  wire logic        cop_req_q,
  input  wire logic [1:0]  cop_sel_q,
  output logic             mem_ready,
  output logic [31:0]      mem_rdata,
  output logic             mem_fault,
  output logic             cop_data_valid,
  output logic [63:0]      cop_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [0:255];
  logic [7:0]  idx;
  initial begin
    {mem_ready, mem_fault, cop_data_valid} = '0;
    mem_rdata = '0;
    cop_data = '0;
  end
  // One access at a time, so racing atomics are served in some serial order
  initial forever begin
    @(posedge mclk);
    #1;
    if (mem_req_q === 1'b1) begin
      repeat (lat) @(posedge mclk);
      #1;
      idx = mem_addr_q[9:2];
      mem_rdata = mem[idx];
      mem_fault = mem_we_q & fault_store;
      mem_ready = 1'b1;
      if (mem_we_q && !fault_store) begin
        case (mem_size_q)
          SZ_BYTE: begin
            mem[idx][8*(3-int'(mem_addr_q[1:0])) +: 8] = mem_wdata_q[7:0];
          end
          SZ_DWORD: begin
            mem[idx] = mem_wdata_q[63:32];
            mem[idx+8'h01] = mem_wdata_q[31:0];
          end
          default: mem[idx] = mem_wdata_q[31:0];
        endcase
      end
      @(posedge mclk);
      #1;
      {mem_ready, mem_fault} = '0;
      mem_rdata = ~mem_rdata;
      // Guard edge so a late-dropping request is not served twice
      @(posedge mclk);
    end
  end
  initial forever begin
    @(posedge mclk);
    #1;
    if (cop_req_q === 1'b1 && mem_req_q !== 1'b1) begin
      repeat (lat) @(posedge mclk);
      #1;
      // Single words repeated in both halves, either half may be taken
      cop_data = cop_sel_q[1] ? cop_word : {2{cop_word[31:0]}};
      cop_data_valid = 1'b1;
      @(posedge mclk);
      #1;
      cop_data_valid = 1'b0;
      cop_data = ~cop_data;
      @(posedge mclk);
    end
  end
endmodule : sase_mem_model

/* File: test/tb_top.sv */
module tb_top import sase_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  num_errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
  logic mclk, rst_n, issue_valid, super_bit, cop_enable_bit, cop_present;
  logic cop_queue_impl, mem_ready, mem_fault, cop_data_valid, fault_store;
  logic busy_q, done_q, trap_q, irq_block_q, rd_we_q, mem_req_q, mem_we_q;
  logic mem_lock_q, cop_req_q, cop_pop_q, got_we, got_pop, blk_bad, got_trap;
  logic [1:0]  mem_size_q, cop_sel_q, lat;
  logic [3:0]  trap_cause_q, icc_q, icc_in, t_trap, t_icc;
  logic [4:0]  rd_addr_q, cop_reg_q, got_rd;
  logic [7:0]  mem_asi_q, got_asi;
  logic [31:0] instr, src_reg_a, src_reg_b, rd_value, rd_wdata_q, got_wd;
  logic [31:0] mem_addr_q, mem_rdata;
  logic [63:0] mem_wdata_q, cop_data, cop_word;
  int seed = 21;
  int num_errors = 0;
  int samples_checked = 0;
  logic [5:0] ops [8] = '{OPX_SWAP, OPX_SWAPA, OPX_LDSTUB, OPX_LDSTUBA,
                          OPX_CWORD, OPX_CDBL, OPX_CSTAT, OPX_CQUE};
  // {opcode, i, super/enable/present/queue, offset, cause}
  logic [17:0] tv [12] = '{
    {OPX_SWAPA, 1'b1, 4'hf, 3'd0, TRAP_ILLEGAL},
    {OPX_SWAPA, 1'b0, 4'h7, 3'd0, TRAP_PRIV},
    {OPX_LDSTUBA, 1'b0, 4'h7, 3'd0, TRAP_PRIV},
    {OPX_SWAP, 1'b0, 4'hf, 3'd2, TRAP_ALIGN},
    {OPX_CWORD, 1'b0, 4'hb, 3'd0, TRAP_COP_OFF},
    {OPX_CDBL, 1'b0, 4'hd, 3'd0, TRAP_COP_OFF},
    {OPX_CQUE, 1'b0, 4'h7, 3'd0, TRAP_PRIV},
    {OPX_CQUE, 1'b0, 4'he, 3'd0, TRAP_COP_FLT},
    {OPX_CWORD, 1'b0, 4'hf, 3'd2, TRAP_ALIGN},
    {OPX_CDBL, 1'b0, 4'hf, 3'd4, TRAP_ALIGN},
    {OPX_CSTAT, 1'b0, 4'hf, 3'd1, TRAP_ALIGN},
    {OPX_CQUE, 1'b0, 4'hf, 3'd4, TRAP_ALIGN}};
  sase_exec u_sase_exec (.mclk(mclk), .rst_n(rst_n), .issue_valid(issue_valid),
    .instr(instr), .src_reg_a(src_reg_a), .src_reg_b(src_reg_b),
    .rd_value(rd_value), .super_bit(super_bit), .cop_enable_bit(cop_enable_bit),
    .cop_present(cop_present), .cop_queue_impl(cop_queue_impl),
    .icc_in(icc_in), .mem_ready(mem_ready), .mem_rdata(mem_rdata),
    .mem_fault(mem_fault), .cop_data_valid(cop_data_valid),
    .cop_data(cop_data), .busy_q(busy_q), .done_q(done_q), .trap_q(trap_q),
    .trap_cause_q(trap_cause_q), .irq_block_q(irq_block_q),
    .rd_we_q(rd_we_q), .rd_addr_q(rd_addr_q), .rd_wdata_q(rd_wdata_q),
    .icc_q(icc_q), .mem_req_q(mem_req_q), .mem_we_q(mem_we_q),
    .mem_lock_q(mem_lock_q), .mem_addr_q(mem_addr_q), .mem_size_q(mem_size_q),
    .mem_asi_q(mem_asi_q), .mem_wdata_q(mem_wdata_q), .cop_req_q(cop_req_q),
    .cop_sel_q(cop_sel_q), .cop_reg_q(cop_reg_q), .cop_pop_q(cop_pop_q));
  sase_mem_model u_mdl (.mclk(mclk), .lat(lat), .fault_store(fault_store),
    .cop_word(cop_word), .mem_req_q(mem_req_q), .mem_we_q(mem_we_q),
    .mem_addr_q(mem_addr_q), .mem_size_q(mem_size_q),
    .mem_wdata_q(mem_wdata_q), .cop_req_q(cop_req_q), .cop_sel_q(cop_sel_q),
    .mem_ready(mem_ready), .mem_rdata(mem_rdata), .mem_fault(mem_fault),
    .cop_data_valid(cop_data_valid), .cop_data(cop_data));
  function automatic logic [31:0] fmt3(logic [5:0] op, logic [4:0] rd,
                                       logic i, logic [12:0] lo);
    return {OP_MEM, rd, op, 5'd1, i, lo};
  endfunction : fmt3
  function automatic logic [31:0] ea_f(logic [31:0] a, b, ins);
    return ins[13] ? a + {{19{ins[12]}}, ins[12:0]} : a + b;
  endfunction : ea_f
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task automatic run(input logic [31:0] ins, a, b, rv);
    int n;
    @(posedge mclk);
    #1;
    {instr, src_reg_a, src_reg_b, rd_value} = {ins, a, b, rv};
    issue_valid = 1'b1;
    icc_in = 4'($random(seed));
    lat = 2'($random(seed));
    @(posedge mclk);
    #1;
    issue_valid = 1'b0;
    {got_we, got_pop, blk_bad, got_wd, got_asi, got_rd, n} = '0;
    // Sample before waiting: a one-cycle answer pulses along with done_q
    while (n < 200) begin
      if (cop_pop_q === 1'b1) got_pop = 1'b1;
      if (rd_we_q === 1'b1) begin
        {got_we, got_wd, got_rd} = {1'b1, rd_wdata_q, rd_addr_q};
      end
      if (mem_req_q === 1'b1) begin
        got_asi = mem_asi_q;
        if (instr[24] ? mem_size_q !== (instr[20] ? SZ_DWORD : SZ_WORD)
            : (irq_block_q !== 1'b1 || mem_lock_q !== 1'b1
               || mem_size_q !== (instr[20] ? SZ_WORD : SZ_BYTE)))
          blk_bad = 1'b1;
      end
      if (cop_req_q === 1'b1 && cop_reg_q !== instr[29:25]) blk_bad = 1'b1;
      if (done_q === 1'b1) break;
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 200) begin
      num_errors++;
      $display("[FAIL] %0t no completion", $time);
    end
    {t_trap, t_icc, got_trap} = {trap_cause_q, icc_q, trap_q};
  endtask : run
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    #400000;
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report();
  end
  initial begin
    logic [31:0] a, b, w, rv, old, ex, em, ea;
    logic [4:0]  rdf;
    logic [21:0] imm;
    logic        alt, byt;
    {rst_n, issue_valid, fault_store, lat, icc_in} = '0;
    {instr, src_reg_a, src_reg_b, rd_value, cop_word} = '0;
    {super_bit, cop_enable_bit, cop_present, cop_queue_impl} = 4'hf;
    repeat (8) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    for (int k = 0; k < 8; k++) begin
      w = $random(seed);
      rdf = (k == 0) ? 5'd0 : w[26:22];
      imm = (k < 2) ? 22'h0 : w[21:0];
      run({OP_FMT2, rdf, FMT2_SETHI, imm}, w, ~w, w);
      `CHK(got_we, rdf != 5'd0)
      if (rdf != 5'd0) `CHK(got_wd, {imm, 10'h0})
      if (rdf != 5'd0) `CHK(got_rd, rdf)
      `CHK(t_icc, icc_in)
    end
    $display("set-high test done");
    for (int j = 0; j < 8; j++) begin
      w = $random(seed);
      alt = ops[j%4][4];
      byt = !ops[j%4][1];
      super_bit = alt | w[31];
      a = 32'h100 + 16 * j;
      b = byt ? {30'h2, w[9:8]} : 32'h8;
      rv = alt ? fmt3(ops[j%4], 5'd3, 1'b0, {w[7:0], 5'd2})
               : fmt3(ops[j%4], 5'd3, 1'b1, {11'h7fe, b[1:0]});
      ea = ea_f(a, b, rv);
      old = $random(seed);
      u_mdl.mem[ea[9:2]] = old;
      ex = byt ? {24'h0, old[8*(3-int'(ea[1:0])) +: 8]} : old;
      em = byt ? old : ~w;
      if (byt) em[8*(3-int'(ea[1:0])) +: 8] = BYTE_ONES;
      run(rv, a, b, ~w);
      `CHK(t_trap, TRAP_NONE)
      `CHK(got_wd, ex)
      `CHK(u_mdl.mem[ea[9:2]], em)
      if (!alt) w[7:0] = super_bit ? ASI_SUP_DATA : ASI_USER_DATA;
      `CHK(got_asi, w[7:0])
      `CHK(blk_bad, 1'b0)
    end
    $display("atomic test done");
    super_bit = 1'b1;
    for (int j = 4; j < 8; j++) begin
      cop_word = {$random(seed), $random(seed)};
      a = 32'h300 + 16 * j;
      ea = a + 32'h8;
      u_mdl.mem[ea[9:2]] = '0;
      u_mdl.mem[ea[9:2]+8'h01] = '0;
      run(fmt3(ops[j], 5'd4, 1'b0, 13'h2), a, 32'h8, '0);
      `CHK(t_trap, TRAP_NONE)
      ex = ops[j][1] ? cop_word[63:32] : cop_word[31:0];
      `CHK(u_mdl.mem[ea[9:2]], ex)
      if (ops[j][1]) `CHK(u_mdl.mem[ea[9:2]+8'h01], cop_word[31:0])
      `CHK(got_pop, ops[j] == OPX_CQUE)
      `CHK(blk_bad, 1'b0)
    end
    $display("coprocessor store test done");
    for (int j = 0; j < 12; j++) begin
      w = $random(seed);
      {super_bit, cop_enable_bit, cop_present, cop_queue_impl} = tv[j][10:7];
      u_mdl.mem[8'h80] = w;
      u_mdl.mem[8'h81] = ~w;
      b = {29'h0, tv[j][6:4]};
      run(fmt3(tv[j][17:12], 5'd5, tv[j][11], {10'h0, b[2:0]}), 32'h200, b, w);
      `CHK(t_trap, tv[j][3:0])
      `CHK(got_we, 1'b0)
      `CHK(got_trap, 1'b1)
      `CHK({u_mdl.mem[8'h80], u_mdl.mem[8'h81]}, {w, ~w})
    end
    $display("trap test done");
    {super_bit, cop_enable_bit, cop_present, cop_queue_impl} = 4'hf;
    fault_store = 1'b1;
    u_mdl.mem[8'h90] = 32'h0055_aa33;
    run(fmt3(OPX_LDSTUB, 5'd6, 1'b1, 13'h0), 32'h240, '0, '0);
    fault_store = 1'b0;
    `CHK(t_trap, TRAP_DACC)
    `CHK(got_trap, 1'b1)
    `CHK(u_mdl.mem[8'h90], 32'h0055_aa33)
    $display("store fault test done");
    final_report();
  end
endmodule : tb_top
